// [design/byte_fifo2.sv]
// small valid/ready buffer between byte receiver and page latch
`timescale 1ns/1ps
module byte_fifo2 #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 2
) (
	// clock, reset, enable
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store_ff [DEPTH];  // entry storage
	logic [PW-1:0]    wr_ptr_ff;         // next slot to fill
	logic [PW-1:0]    rd_ptr_ff;         // next slot to drain
	logic [CW-1:0]    count_ff;          // entries held
	logic [PW-1:0]    nxt_wr_ptr;
	logic [PW-1:0]    nxt_rd_ptr;
	logic [CW-1:0]    nxt_count;
	logic             push;
	logic             pop;

	// honest full and empty flags
	assign in_ready  = (count_ff != CW'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = store_ff[rd_ptr_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count  = count_ff;
		if (push) begin
			nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	// registers, frozen while ce is low
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else if (ce) begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
			if (push) begin
				store_ff[wr_ptr_ff] <= in_data;
			end
		end
	end
endmodule

// [design/eeprom_slave.sv]
// serial eeprom slave: select decode, writes, reads, id page, ecc
// Overview of operation
// - select byte: type, three strap bits, rw
// - answer only when strap field matches straps
// - rw flag one reads, zero writes
// - ack match in ninth bit, else standby
// - write takes two acked address bytes, high first
// - write cycle starts only on stop after data ack
// - counter ends after last modified byte
// - busy write cycle: release data, ignore bus
// - protect high: no write, data bytes not acked
// - page write wraps inside 64-byte page
// - id page write: own type, bit10 zero
// - locked id page refuses data bytes
// - lock command: bit10 one, data bit1 locks
// - four-byte groups carry single-bit correction
// - no select ack while busy, ack after
// - reads ignore write protect
// - master no-ack after read byte ends transfer
// - random read via dummy write, repeated start
// - current read outputs counter byte, then increments
// - one counter for array and id page
// - sequential read wraps to address zero
// - protect high still acks select and address
// - protect low or open means writes enabled
// - data sampled on serial clock rising edge
// - open strap inputs read as low
`timescale 1ns/1ps
`include "eeprom_params.svh"
module eeprom_slave #(
	parameter int         WRITE_CYCLES = `WRITE_CYCLES,
	parameter logic [3:0] MEM_TYPE_ID  = 4'h5,  // arbitrary value
	parameter logic [3:0] IDP_TYPE_ID  = 4'h6   // arbitrary value
) (
	// clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// serial bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// straps and protection
	input  wire logic [2:0] chip_select_straps,
	input  wire logic       write_protect_in,
	// status
	output logic            write_busy,
	output logic            id_locked
);
	// pin synchronisers and edge history
	logic       scl_m_ff, scl_s_ff, scl_d_ff;
	logic       sda_m_ff, sda_s_ff, sda_d_ff;
	logic [2:0] ces_m_ff, ces_s_ff;
	logic       wp_m_ff, wp_s_ff;
	logic       rise, fall, start_ev, stop_ev;

	// protocol state
	eeprom_pkg::proto_state_t state_ff, nxt_state;
	logic [3:0]  cnt_ff, nxt_cnt;        // bit slot 0..8
	logic [7:0]  shr_ff, nxt_shr;        // receive shifter
	logic [7:0]  tx_ff, nxt_tx;          // byte being sent
	logic [7:0]  hi_ff, nxt_hi;          // high address byte
	logic [14:0] addr_ff, nxt_addr;      // shared address counter
	logic [8:0]  page_ff, nxt_page;      // page_select_bits
	logic [5:0]  woff_ff, nxt_woff;      // in-page write offset
	logic [6:0]  cidx_ff, nxt_cidx;      // commit walk index
	logic [31:0] wt_ff, nxt_wt;          // busy interval count
	logic        ack_ff, nxt_ack;        // ack to drive in slot 9
	logic        rw_ff, nxt_rw;          // read flag of select
	logic        idsel_ff, nxt_idsel;    // id page selected
	logic        lockcmd_ff, nxt_lockcmd;
	logic        last_ff, nxt_last;      // previous slot was data ack
	logic        pend_ff, nxt_pend;      // a byte awaits commit
	logic        oe_n_ff, nxt_oe_n;
	logic        lock_ff, nxt_lock;
	logic        busy_ff;
	logic [7:0]  byte_in;
	logic [7:0]  rd_byte;
	logic        push;
	logic        commit_done;
	logic        page_clr;

	// page latch and the group merge of the commit walk
	logic [12:0] grp_idx;                // group index being rewritten
	logic [31:0] grp_word;               // corrected group with new byte
	logic [7:0]  pg_data_ff [`PAGE_BYTES];
	logic        pg_flag_ff [`PAGE_BYTES];
	logic        lock_pend_ff, nxt_lock_pend;

	// write buffer handshake
	logic        buf_in_ready;
	logic        buf_out_valid;
	logic        buf_out_ready;
	logic [`WBUF_WIDTH-1:0] buf_out_data;

	// single-bit hamming code over one group
	function automatic logic [5:0] ecc_calc(input logic [31:0] d);
		logic [5:0] c;
		logic [5:0] p;
		c = '0;
		p = 6'h02;
		for (int k = 0; k < 32; k++) begin
			p = p + 6'h01;
			if ((p & (p - 6'h01)) == 6'h00) begin
				p = p + 6'h01;
			end
			if (d[k]) begin
				c = c ^ p;
			end
		end
		return c;
	endfunction

	// flip the data bit the syndrome points at
	function automatic logic [31:0] ecc_fix(input logic [31:0] d,
			input logic [5:0] chk);
		logic [5:0] s;
		logic [5:0] p;
		logic [31:0] r;
		s = chk ^ ecc_calc(d);
		p = 6'h02;
		r = d;
		for (int k = 0; k < 32; k++) begin
			p = p + 6'h01;
			if ((p & (p - 6'h01)) == 6'h00) begin
				p = p + 6'h01;
			end
			if (s == p) begin
				r[k] = ~d[k];
			end
		end
		return r;
	endfunction

	// delivered state: every byte erased to ff with valid code
	localparam logic [5:0] ERASED_CHK = ecc_calc(32'hffffffff);
	// storage: ecc-protected words and id page, written by commit only
	logic [31:0] mem_word [`MEM_WORDS] = '{default: 32'hffffffff};
	logic [5:0]  mem_chk  [`MEM_WORDS] = '{default: ERASED_CHK};
	logic [7:0]  id_mem   [`PAGE_BYTES] = '{default: 8'hff};

	// two-flop pin sync, open pins resolve low
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			{scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
			{sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
			ces_m_ff <= 3'h0;
			ces_s_ff <= 3'h0;
			wp_m_ff  <= 1'b0;
			wp_s_ff  <= 1'b0;
		end else if (ce) begin
			{scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_in, scl_m_ff, scl_s_ff};
			{sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_m_ff, sda_s_ff};
			ces_m_ff <= chip_select_straps;
			ces_s_ff <= ces_m_ff;
			wp_m_ff  <= write_protect_in;
			wp_s_ff  <= wp_m_ff;
		end
	end

	// bus events seen on synchronised pins
	assign rise     = scl_s_ff && !scl_d_ff;
	assign fall     = !scl_s_ff && scl_d_ff;
	assign start_ev = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
	assign stop_ev  = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
	assign byte_in  = {shr_ff[6:0], sda_s_ff};
	assign commit_done = (state_ff == eeprom_pkg::ST_WAIT) && (wt_ff == '0);
	assign page_clr = commit_done || (start_ev && !busy_ff);

	// read source picked by select type only
	always_comb begin
		logic [31:0] w;
		w = ecc_fix(mem_word[addr_ff[14:2]], mem_chk[addr_ff[14:2]]);
		rd_byte = idsel_ff ? id_mem[addr_ff[5:0]] : w[8*addr_ff[1:0] +: 8];
	end

	// protocol next state
	always_comb begin
		nxt_state = state_ff;   nxt_cnt = cnt_ff;     nxt_shr = shr_ff;
		nxt_tx = tx_ff;         nxt_hi = hi_ff;       nxt_addr = addr_ff;
		nxt_page = page_ff;     nxt_woff = woff_ff;   nxt_cidx = cidx_ff;
		nxt_wt = wt_ff;         nxt_ack = ack_ff;     nxt_rw = rw_ff;
		nxt_idsel = idsel_ff;   nxt_lockcmd = lockcmd_ff;
		nxt_last = last_ff;     nxt_pend = pend_ff;   nxt_oe_n = oe_n_ff;
		nxt_lock = lock_ff;     push = 1'b0;
		unique case (state_ff)
			eeprom_pkg::ST_COMMIT: begin
				// one page latch entry per cycle into the array, or into the id page when selected
				nxt_oe_n = 1'b1;
				nxt_cidx = cidx_ff + 7'h01;
				if (cidx_ff == 7'(`PAGE_BYTES - 1)) begin
					nxt_state = eeprom_pkg::ST_WAIT;
					nxt_wt = 32'(WRITE_CYCLES - 1);
				end
			end
			eeprom_pkg::ST_WAIT: begin
				// deaf and silent until count ends
				nxt_oe_n = 1'b1;
				if (wt_ff != '0) begin
					nxt_wt = wt_ff - 32'h1;
				end else begin
					nxt_state = eeprom_pkg::ST_IDLE;
					nxt_pend = 1'b0;
					nxt_lock = lock_ff || lock_pend_ff;
					// counter just past last modified byte
					nxt_addr = {page_ff, woff_ff};
				end
			end
			default: begin
				if (start_ev) begin
					nxt_state = eeprom_pkg::ST_DEVSEL;
					nxt_cnt = 4'h0;
					nxt_oe_n = 1'b1;
					nxt_ack = 1'b0;
					nxt_last = 1'b0;
					nxt_pend = 1'b0;
				end else if (stop_ev) begin
					// only the slot after a data ack commits
					nxt_oe_n = 1'b1;
					nxt_last = 1'b0;
					nxt_cidx = 7'h00;
					nxt_state = (last_ff && pend_ff) ? eeprom_pkg::ST_COMMIT
						: eeprom_pkg::ST_IDLE;
				end else if (rise && state_ff != eeprom_pkg::ST_IDLE) begin
					// the rise just before a stop still counts as slot ten
					if (cnt_ff != 4'h0) begin
						nxt_last = 1'b0;
					end
					if (cnt_ff != 4'h8) begin
						nxt_shr = byte_in;
						nxt_cnt = cnt_ff + 4'h1;
						nxt_ack = 1'b0;
						if (cnt_ff == 4'h7) begin
							unique case (state_ff)
								eeprom_pkg::ST_DEVSEL: begin
									nxt_rw = byte_in[0];
									nxt_idsel = (byte_in[7:4] == IDP_TYPE_ID);
									nxt_ack = (byte_in[3:1] == ces_s_ff) &&
										((byte_in[7:4] == MEM_TYPE_ID) ||
										(byte_in[7:4] == IDP_TYPE_ID));
									if (!nxt_ack) begin
										nxt_state = eeprom_pkg::ST_IDLE;
									end
								end
								eeprom_pkg::ST_ADDR_HI: begin
									nxt_hi = byte_in;
									nxt_ack = 1'b1;
								end
								eeprom_pkg::ST_ADDR_LO: begin
									nxt_ack = 1'b1;
									nxt_addr = {hi_ff[6:0], byte_in};
									nxt_page = {hi_ff[6:0], byte_in[7:6]};
									nxt_woff = byte_in[5:0];
									nxt_lockcmd = idsel_ff &&
										hi_ff[`ID_LOCK_SELECT_POS];
								end
								eeprom_pkg::ST_WDATA: begin
									nxt_ack = !wp_s_ff && buf_in_ready &&
										!(idsel_ff && lock_ff);
									push = nxt_ack;
									nxt_pend = pend_ff || nxt_ack;
									nxt_woff = woff_ff + 6'h01;
								end
								default: begin
									nxt_ack = 1'b0;
								end
							endcase
						end
					end else begin
						// ninth slot closes the byte
						nxt_cnt = 4'h0;
						nxt_ack = 1'b0;
						unique case (state_ff)
							eeprom_pkg::ST_DEVSEL: begin
								// current read, load then count on
								if (rw_ff) begin
									nxt_state = eeprom_pkg::ST_RDATA;
									nxt_tx = rd_byte;
									nxt_addr = addr_ff + 15'h0001;
								end else begin
									nxt_state = eeprom_pkg::ST_ADDR_HI;
								end
							end
							eeprom_pkg::ST_ADDR_HI: begin
								nxt_state = eeprom_pkg::ST_ADDR_LO;
							end
							eeprom_pkg::ST_ADDR_LO: begin
								// dummy write ends here on restart
								nxt_state = eeprom_pkg::ST_WDATA;
							end
							eeprom_pkg::ST_WDATA: begin
								nxt_last = ack_ff;
							end
							default: begin
								if (!sda_s_ff) begin
									nxt_tx = rd_byte;
									nxt_addr = addr_ff + 15'h0001;
								end else begin
									nxt_state = eeprom_pkg::ST_IDLE;
								end
							end
						endcase
					end
				end else if (fall) begin
					// drive ack low, or the outgoing bit on the low phase
					if (cnt_ff == 4'h8) begin
						nxt_oe_n = !ack_ff;
					end else if (state_ff == eeprom_pkg::ST_RDATA) begin
						nxt_oe_n = tx_ff[~cnt_ff[2:0]];
					end else begin
						nxt_oe_n = 1'b1;
					end
				end
			end
		endcase
	end

	// protocol registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= eeprom_pkg::ST_IDLE;
			{cnt_ff, shr_ff, tx_ff, hi_ff} <= '0;
			{addr_ff, page_ff, woff_ff, cidx_ff, wt_ff} <= '0;
			{ack_ff, rw_ff, idsel_ff, lockcmd_ff, last_ff, pend_ff} <= '0;
			oe_n_ff <= 1'b1;
			lock_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;   cnt_ff <= nxt_cnt;     shr_ff <= nxt_shr;
			tx_ff <= nxt_tx;         hi_ff <= nxt_hi;       addr_ff <= nxt_addr;
			page_ff <= nxt_page;     woff_ff <= nxt_woff;   cidx_ff <= nxt_cidx;
			wt_ff <= nxt_wt;         ack_ff <= nxt_ack;     rw_ff <= nxt_rw;
			idsel_ff <= nxt_idsel;   lockcmd_ff <= nxt_lockcmd;
			last_ff <= nxt_last;     pend_ff <= nxt_pend;   oe_n_ff <= nxt_oe_n;
			lock_ff <= nxt_lock;
			busy_ff <= (nxt_state == eeprom_pkg::ST_COMMIT) ||
				(nxt_state == eeprom_pkg::ST_WAIT);
		end
	end

	// accepted data bytes wait here while the latch is busy
	assign buf_out_ready = !busy_ff;
	byte_fifo2 #(.WIDTH(`WBUF_WIDTH), .DEPTH(`WBUF_DEPTH)) wbuf (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (buf_in_ready),
		.in_data   ({lockcmd_ff, woff_ff, byte_in}),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	// lock byte with bit1 set arms the permanent lock
	always_comb begin
		nxt_lock_pend = lock_pend_ff;
		if (page_clr) begin
			nxt_lock_pend = 1'b0;
		end else if (buf_out_valid && buf_out_ready &&
				buf_out_data[14] && buf_out_data[`ID_LOCK_DATA_POS]) begin
			nxt_lock_pend = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lock_pend_ff <= 1'b0;
		end else if (ce) begin
			lock_pend_ff <= nxt_lock_pend;
		end
	end

	// page latch, one entry per offset
	for (genvar g = 0; g < `PAGE_BYTES; g++) begin : pg_entry
		logic       nxt_flag;
		logic [7:0] nxt_data;
		always_comb begin
			nxt_flag = pg_flag_ff[g];
			nxt_data = pg_data_ff[g];
			if (page_clr) begin
				nxt_flag = 1'b0;
			end else if (buf_out_valid && buf_out_ready && !buf_out_data[14]
					&& buf_out_data[13:8] == 6'(g)) begin
				nxt_flag = 1'b1;
				nxt_data = buf_out_data[7:0];
			end
		end
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				pg_flag_ff[g] <= 1'b0;
				pg_data_ff[g] <= 8'h00;
			end else if (ce) begin
				pg_flag_ff[g] <= nxt_flag;
				pg_data_ff[g] <= nxt_data;
			end
		end
	end

	// corrected group with the latched byte merged in
	always_comb begin
		grp_idx  = {page_ff, cidx_ff[5:2]};
		grp_word = ecc_fix(mem_word[grp_idx], mem_chk[grp_idx]);
		grp_word[8*cidx_ff[1:0] +: 8] = pg_data_ff[cidx_ff[5:0]];
	end

	// an array byte write rewrites its whole group with new code, an id page byte only itself
	always_ff @(posedge core_clk) begin
		if (ce && state_ff == eeprom_pkg::ST_COMMIT &&
				pg_flag_ff[cidx_ff[5:0]]) begin
			if (idsel_ff) begin
				id_mem[cidx_ff[5:0]] <= pg_data_ff[cidx_ff[5:0]];
			end else begin
				mem_word[grp_idx] <= grp_word;
				mem_chk[grp_idx]  <= ecc_calc(grp_word);
			end
		end
	end

	// outputs straight from flops
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else if (ce) begin
			sda_out <= 1'b0;
		end
	end
	assign sda_oe_n   = oe_n_ff;
	assign write_busy = busy_ff;
	assign id_locked  = lock_ff;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence stop_after_data;
		ce && last_ff && pend_ff && stop_ev && !busy_ff;
	endsequence
	AST_STOP_COMMITS: assert property (stop_after_data |=>
		state_ff == eeprom_pkg::ST_COMMIT ##64 state_ff == eeprom_pkg::ST_WAIT
		or !ce) else $error("stop after data ack did not start commit");
	AST_STOP_NO_WRITE: assert property (ce && stop_ev && !last_ff &&
		!busy_ff |=> state_ff == eeprom_pkg::ST_IDLE)
		else $error("stray stop started a write");
	AST_BUSY_SILENT: assert property (busy_ff |-> sda_oe_n)
		else $error("data driven during write cycle");
	AST_WP_NACK: assert property (ce && rise && wp_s_ff && cnt_ff == 4'h7 &&
		state_ff == eeprom_pkg::ST_WDATA |=> !ack_ff && !push)
		else $error("protected data byte acknowledged");
	AST_MISMATCH_IDLE: assert property (ce && rise && cnt_ff == 4'h7 &&
		state_ff == eeprom_pkg::ST_DEVSEL && byte_in[3:1] != ces_s_ff
		|=> state_ff == eeprom_pkg::ST_IDLE && !ack_ff)
		else $error("foreign select byte not dropped");
	AST_READ_NACK_END: assert property (ce && rise && cnt_ff == 4'h8 &&
		sda_s_ff && state_ff == eeprom_pkg::ST_RDATA
		|=> state_ff == eeprom_pkg::ST_IDLE)
		else $error("read continued after master no-ack");
	AST_START_RESTART: assert property (ce && start_ev && !busy_ff
		|=> state_ff == eeprom_pkg::ST_DEVSEL && cnt_ff == 4'h0)
		else $error("start did not restart decoding");
	AST_WAIT_END: assert property (ce && commit_done
		|=> state_ff == eeprom_pkg::ST_IDLE && !busy_ff)
		else $error("write cycle did not end on count");
	AST_LOCK_NACK: assert property (ce && rise && cnt_ff == 4'h7 && lock_ff &&
		idsel_ff && state_ff == eeprom_pkg::ST_WDATA |=> !ack_ff)
		else $error("locked id page byte acknowledged");
endmodule

// [pkg/eeprom_params.svh]
// timing counts, field positions and sizes of the eeprom slave
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// core clock period and internal write time in nanoseconds
`define CLK_PERIOD_NS      20
`define INTERNAL_WRITE_NS  5000000
// least time rounds up to whole core cycles
`define WRITE_CYCLES       ((`INTERNAL_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// array geometry
`define MEM_WORDS          8192
`define PAGE_BYTES         64
// id_lock_select_bit (address bit 10) as a bit of the high address byte
`define ID_LOCK_SELECT_POS 2
// lock data byte bit that requests the permanent lock
`define ID_LOCK_DATA_POS   1
// two-entry buffer depth and entry width {lock, offset[5:0], data[7:0]}
`define WBUF_DEPTH         2
`define WBUF_WIDTH         15

`endif

// [pkg/eeprom_pkg.sv]
// types shared by the eeprom slave files
package eeprom_pkg;
	// protocol states of the slave
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_DEVSEL  = 3'h1,
		ST_ADDR_HI = 3'h2,
		ST_ADDR_LO = 3'h3,
		ST_WDATA   = 3'h4,
		ST_RDATA   = 3'h5,
		ST_COMMIT  = 3'h6,
		ST_WAIT    = 3'h7
	} proto_state_t;
endpackage

// [sim/i2c_master_model.sv]
// serial bus master model driving clock and data
`timescale 1ns/1ps
module i2c_master_model (
	// core clock for pacing
	input  wire logic core_clk,
	// bus lines, data released when high
	output logic      scl,
	output logic      sda_rel,
	input  wire logic sda_line
);
	// idle bus: clock stands high, data released
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// half phase of two core cycles
	task automatic hp();
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	// full phase of four core cycles
	task automatic ph();
		hp();
		hp();
	endtask
	task automatic start();
		hp();
		sda_rel = 1'b1;
		hp();
		scl = 1'b1;
		ph();
		sda_rel = 1'b0;
		ph();
		scl = 1'b0;
	endtask
	// stop: data rises with clock high
	task automatic stop();
		hp();
		sda_rel = 1'b0;
		hp();
		scl = 1'b1;
		ph();
		sda_rel = 1'b1;
		ph();
	endtask
	// data changes only mid low phase
	task automatic bit_x(input logic b, output logic s);
		hp();
		sda_rel = b;
		hp();
		scl = 1'b1;
		ph();
		s = sda_line;
		scl = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
		end
		bit_x(1'b1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(!ack, s);
	endtask
endmodule

// [sim/tb.sv]
// self-checking bench of the eeprom slave
`timescale 1ns/1ps
module tb;
	localparam int         WR_CYC = 50;
	localparam logic [3:0] MT = 4'h5;
	localparam logic [3:0] IT = 4'h6;
	localparam logic [2:0] CS = 3'h5;
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       ce = 1'b1;
	logic       wp = 1'b0;
	logic [2:0] cs = CS;
	logic       scl, sda_rel, sda, sda_out, sda_oe_n, busy, lkd, k;
	logic [7:0] b0, b1;
	int         n_mismatch = 0;
	int         checked = 0;
	int         cyc = 0;
	// wired-and data line with pull-up
	assign sda = sda_rel & (sda_oe_n | sda_out);
	always #10 core_clk = ~core_clk;
	eeprom_slave #(.WRITE_CYCLES(WR_CYC), .MEM_TYPE_ID(MT),
		.IDP_TYPE_ID(IT)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.chip_select_straps(cs), .write_protect_in(wp),
		.write_busy(busy), .id_locked(lkd));
	i2c_master_model master_u (.core_clk(core_clk), .scl(scl),
		.sda_rel(sda_rel), .sda_line(sda));
	// verdict and end of run
	task automatic print_verdict();
		if (n_mismatch == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// compare one value
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// write n bytes from d upward, data ack expected e
	task automatic wr(input logic [3:0] ty, input logic [15:0] a,
		input logic [7:0] d, input int n, input logic e);
		master_u.start();
		master_u.wbyte({ty, CS, 1'b0}, k);
		chk(8'(k), 8'h01);
		master_u.wbyte(a[15:8], k);
		chk(8'(k), 8'h01);
		master_u.wbyte(a[7:0], k);
		chk(8'(k), 8'h01);
		for (int i = 0; i < n; i++) begin
			master_u.wbyte(d + 8'(i), k);
			chk(8'(k), 8'(e));
		end
		master_u.stop();
	endtask
	// select polling until acked
	task automatic poll(input logic bz);
		int p;
		p = 0;
		master_u.hp();
		chk(8'(busy), 8'(bz));
		master_u.start();
		master_u.wbyte({MT, CS, 1'b0}, k);
		chk(8'(k), 8'(!bz));
		while (k !== 1'b1 && p < 20) begin
			master_u.stop();
			master_u.start();
			master_u.wbyte({MT, CS, 1'b0}, k);
			p++;
		end
		chk(8'(k), 8'h01);
		master_u.stop();
	endtask
	// random or current read of one or two bytes
	task automatic rd(input logic [3:0] ty, input logic [15:0] a,
		input logic rnd, input int n);
		if (rnd) begin
			master_u.start();
			master_u.wbyte({ty, CS, 1'b0}, k);
			master_u.wbyte(a[15:8], k);
			master_u.wbyte(a[7:0], k);
		end
		master_u.start();
		master_u.wbyte({ty, CS, 1'b1}, k);
		chk(8'(k), 8'h01);
		master_u.rbyte(n > 1, b0);
		if (n > 1) begin
			master_u.rbyte(1'b0, b1);
		end
		master_u.stop();
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk({5'h00, busy, lkd, sda_oe_n}, 8'h01);
		wr(MT, 16'h0124, 8'h77, 1, 1'b1);
		poll(1'b1);
		wr(MT, 16'h0123, 8'h3c, 1, 1'b1);
		poll(1'b1);
		rd(MT, 16'h0000, 1'b0, 1);
		chk(b0, 8'h77);
		rd(MT, 16'h0123, 1'b1, 2);
		chk(b0, 8'h3c);
		chk(b1, 8'h77);
		master_u.start();
		master_u.wbyte({MT, ~CS, 1'b0}, k);
		chk(8'(k), 8'h00);
		master_u.stop();
		wr(MT, 16'h0200, 8'h00, 0, 1'b1);
		poll(1'b0);
		wr(MT, 16'h003e, 8'ha0, 3, 1'b1);
		poll(1'b1);
		rd(MT, 16'h003e, 1'b1, 2);
		chk(b0, 8'ha0);
		chk(b1, 8'ha1);
		wr(MT, 16'h7fff, 8'h5a, 1, 1'b1);
		poll(1'b1);
		rd(MT, 16'h7fff, 1'b1, 2);
		chk(b0, 8'h5a);
		chk(b1, 8'ha2);
		wp = 1'b1;
		wr(MT, 16'h0123, 8'hee, 1, 1'b0);
		poll(1'b0);
		rd(MT, 16'h0123, 1'b1, 1);
		chk(b0, 8'h3c);
		wp = 1'b0;
		wr(IT, 16'h0005, 8'h42, 1, 1'b1);
		poll(1'b1);
		rd(IT, 16'h0005, 1'b1, 1);
		chk(b0, 8'h42);
		wr(IT, 16'h0400, 8'h02, 1, 1'b1);
		poll(1'b1);
		chk(8'(lkd), 8'h01);
		wr(IT, 16'h0005, 8'h99, 1, 1'b0);
		poll(1'b0);
		rd(IT, 16'h0005, 1'b1, 1);
		chk(b0, 8'h42);
		print_verdict();
	end
endmodule
